// *** rtl/idc_defs.vh ***
`ifndef IDC_DEFS_VH
`define IDC_DEFS_VH

// Register offsets: 8-byte group numbers, then byte offsets; 16-bit data path
`define IDC_A_DI 4'h0
`define IDC_A_DO 4'h1
`define IDC_A_EDGE_LO 4'h2
`define IDC_A_EDGE_HI 4'h3
`define IDC_A_STATE 4'h4
`define IDC_A_FEN 4'h5
`define IDC_A_FPRE_LO 7'h30
`define IDC_A_FPRE_HI 7'h32
`define IDC_A_WDV_LO 7'h34
`define IDC_A_WDV_HI 7'h36
`define IDC_A_WDCTL 7'h38
`define IDC_A_WDCLR 7'h3a
`define IDC_A_EECTL 7'h3c
`define IDC_A_CARD 7'h3e
`define IDC_A_PORTID 7'h40

// Field positions
`define IDC_WDCTL_EN 0
`define IDC_WDST_EXP 0
`define IDC_WDST_EN 1
`define IDC_EE_STORE 15
`define IDC_EE_DONE 0

// Reset values
`define IDC_RST_16 16'h0000
`define IDC_RST_32 32'h00000000
`define IDC_RST_64 64'h0000000000000000

// Timing
`define IDC_CLK_MHZ 20
`define IDC_STEP_NS 100
`define IDC_STEP_CYC ((`IDC_STEP_NS * `IDC_CLK_MHZ) / 1000)
`define IDC_FLT_MIN_NS 200
`define IDC_FLT_MIN_PRE (`IDC_FLT_MIN_NS / `IDC_STEP_NS)

`endif

// *** rtl/idc_filter.v ***
`timescale 1ns/1ps
`include "idc_defs.vh"

module idc_filter (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Sample strobe and data
   input wire sample_tick,
   input wire [63:0] din,
   input wire [63:0] en,
   input wire [31:0] preset,
   // Filtered levels
   output reg [63:0] dout
);

   reg [31:0] cnt_reg;
   reg [63:0] samp_reg;
   reg [63:0] prev_reg;
   wire [31:0] half;
   wire ftick;
   wire [63:0] stable;
   wire [63:0] filt_next;

   // Filter clock is half the interval, at least one sample period
   assign half = (preset < `IDC_FLT_MIN_PRE) ? 32'h00000001 : {1'b0, preset[31:1]};
   assign ftick = sample_tick && (cnt_reg >= half - 32'h00000001);
   assign stable = ~(samp_reg ^ prev_reg);
   // New level accepted only after two equal filter-clock samples
   assign filt_next = (samp_reg & stable) | (dout & ~stable);

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= `IDC_RST_32;
         samp_reg <= `IDC_RST_64;
         prev_reg <= `IDC_RST_64;
         dout <= `IDC_RST_64;
      end else begin
         if (sample_tick) begin
            samp_reg <= din;
            cnt_reg <= ftick ? `IDC_RST_32 : cnt_reg + 32'h00000001;
         end
         if (ftick) begin
            prev_reg <= samp_reg;
         end
         dout <= (~en & din) | (en & (ftick ? filt_next : dout));
      end
   end

endmodule // idc_filter

// *** rtl/idc_wdog.v ***
`timescale 1ns/1ps
`include "idc_defs.vh"

module idc_wdog (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Control
   input wire enable,
   input wire clear,
   input wire [31:0] preset,
   // Status
   output reg expired
);

   reg [1:0] step_reg;
   reg [31:0] cnt_reg;
   wire step;

   assign step = ({30'h00000000, step_reg} == `IDC_STEP_CYC - 1);

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         step_reg <= 2'h0;
         cnt_reg <= `IDC_RST_32;
         expired <= 1'b0;
      end else if (!enable) begin
         step_reg <= 2'h0;
         cnt_reg <= preset;
         expired <= 1'b0;
      end else begin
         step_reg <= step ? 2'h0 : step_reg + 2'h1;
         if (clear && !expired) begin
            cnt_reg <= preset;
            step_reg <= 2'h0;
         end else if (step && !expired) begin
            // Counts in 100 ns steps down to zero
            if (cnt_reg == `IDC_RST_32) begin
               expired <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - 32'h00000001;
            end
         end
      end
   end

endmodule // idc_wdog

// *** rtl/idc_top.v ***
`timescale 1ns/1ps
`include "idc_defs.vh"

// Contract
// - Every input feeds interrupt logic
// - Edge registers select enabled interrupt edges
// - All sources merge onto one request
// - State, rising, falling, port-identify registers
// - Pass full-interval pulses, block half-interval
// - Per-channel filter enable, shared interval
// - Sample inputs every 100 ns
// - Filter clock is half the interval
// - Accept level stable two filter edges
// - Interval preset written as two halves
// - Valid change delayed up to one interval
// - Outputs start from stored power-up image
// - Stored power-up image starts all zeros
// - Watchdog expiry forces outputs safe
// - Expired watchdog blocks writes until disabled
// - Watchdog counts 32-bit value, 100 ns steps
// - Card number at 3Eh, bits 3:0
// - Switch OFF reads one, ON zero
// - Hardware reset off; hot reset jumper-selected

module idc_top (
   // Clock and reset
   input wire CLOCK,
   input wire RST_B,
   // Host register port, 16-bit words
   input wire [6:0] ADDR,
   input wire WR,
   input wire RD,
   input wire [15:0] WDATA,
   output reg [15:0] RDATA,
   output wire IRQ,
   // Field pins
   input wire [63:0] DI,
   output wire [63:0] DO,
   input wire SAMPLE_CLK,
   input wire HOT_RESET_B,
   input wire HOT_RESET_OUTPUT_JUMPER,
   input wire [3:0] CARD_NUMBER_DIP_SWITCH
);

   localparam SW = 71;
   // Hot-reset bit idles high, so reset release gives no false edge
   localparam [SW-1:0] SYNC_IDLE = {4'h0, 3'b010, 64'h0000000000000000};

   // Replace one 16-bit slice of a 64-bit image
   function [63:0] put16;
      input [63:0] old;
      input [1:0] idx;
      input [15:0] val;
      begin
         put16 = old;
         case (idx)
            2'h0: put16[15:0] = val;
            2'h1: put16[31:16] = val;
            2'h2: put16[47:32] = val;
            default: put16[63:48] = val;
         endcase
      end
   endfunction

   // Select one 16-bit slice of a 64-bit image
   function [15:0] get16;
      input [63:0] img;
      input [1:0] idx;
      begin
         case (idx)
            2'h0: get16 = img[15:0];
            2'h1: get16 = img[31:16];
            2'h2: get16 = img[47:32];
            default: get16 = img[63:48];
         endcase
      end
   endfunction

   // Pin synchronisers
   reg [SW-1:0] s1_reg;
   reg [SW-1:0] s2_reg;
   reg [SW-1:0] s3_reg;
   reg [SW-1:0] pin_reg;
   wire [SW-1:0] agree;
   wire [63:0] di_pin;
   wire sclk_pin;
   wire hot_pin;
   wire jumper_pin;
   wire [3:0] card_number;

   // Register state
   reg [63:0] do_reg;
   reg [63:0] rise_reg;
   reg [63:0] fall_reg;
   reg [63:0] state_reg;
   reg [63:0] fen_reg;
   reg [63:0] store_reg;
   reg [31:0] fpre_reg;
   reg [31:0] wdv_reg;
   reg wden_reg;
   reg wdclr_reg;
   reg ee_done_reg;
   reg sclk_d_reg;
   reg hot_d_reg;
   reg boot_reg;
   reg exp_d_reg;
   reg [63:0] filt_d_reg;

   // Next values
   reg [63:0] do_next;
   reg [63:0] rise_next;
   reg [63:0] fall_next;
   reg [63:0] state_next;
   reg [63:0] fen_next;
   reg [63:0] store_next;
   reg [31:0] fpre_next;
   reg [31:0] wdv_next;
   reg wden_next;
   reg ee_done_next;
   reg [15:0] rdata_next;

   wire [63:0] filt;
   wire [63:0] rise_ev;
   wire [63:0] fall_ev;
   wire [63:0] set_ev;
   wire [7:0] port_id;
   wire sample_tick;
   wire hot_ev;
   wire expired;
   wire wr_ok;
   wire [3:0] grp;
   wire [1:0] slice;
   wire [1:0] eslice;

   // Change counts only once stages two and three agree
   assign agree = ~(s2_reg ^ s3_reg);
   assign di_pin = pin_reg[63:0];
   assign sclk_pin = pin_reg[64];
   assign hot_pin = pin_reg[65];
   assign jumper_pin = pin_reg[66];
   assign card_number = pin_reg[70:67];

   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         s1_reg <= SYNC_IDLE;
         s2_reg <= SYNC_IDLE;
         s3_reg <= SYNC_IDLE;
         pin_reg <= SYNC_IDLE;
         sclk_d_reg <= 1'b0;
         hot_d_reg <= 1'b1;
      end else begin
         s1_reg <= {CARD_NUMBER_DIP_SWITCH, HOT_RESET_OUTPUT_JUMPER, HOT_RESET_B, SAMPLE_CLK, DI};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         pin_reg <= (s3_reg & agree) | (pin_reg & ~agree);
         sclk_d_reg <= sclk_pin;
         hot_d_reg <= hot_pin;
      end
   end

   assign sample_tick = sclk_pin & ~sclk_d_reg;
   // Hot reset acts on its release edge
   assign hot_ev = hot_pin & ~hot_d_reg;

   idc_filter u_filter (
      .clk(CLOCK),
      .rst_b(RST_B),
      .sample_tick(sample_tick),
      .din(di_pin),
      .en(fen_reg),
      .preset(fpre_reg),
      .dout(filt)
   );

   idc_wdog u_wdog (
      .clk(CLOCK),
      .rst_b(RST_B),
      .enable(wden_reg),
      .clear(wdclr_reg),
      .preset(wdv_reg),
      .expired(expired)
   );

   // Edge events after the filter
   assign rise_ev = filt & ~filt_d_reg & rise_reg;
   assign fall_ev = ~filt & filt_d_reg & fall_reg;
   assign set_ev = rise_ev | fall_ev;

   genvar p;
   generate
      for (p = 0; p < 8; p = p + 1) begin : g_port
         assign port_id[p] = |state_reg[p*8+7:p*8];
      end
   endgenerate

   assign IRQ = |state_reg;
   assign DO = do_reg;

   // Once expired only the watchdog control stays writable
   assign wr_ok = WR && (!expired || ADDR == `IDC_A_WDCTL);
   assign grp = ADDR[6:3];
   assign slice = ADDR[2:1];
   assign eslice = ADDR[3:2];

   always @* begin
      do_next = do_reg;
      rise_next = rise_reg;
      fall_next = fall_reg;
      fen_next = fen_reg;
      store_next = store_reg;
      fpre_next = fpre_reg;
      wdv_next = wdv_reg;
      wden_next = wden_reg;
      ee_done_next = ee_done_reg;
      state_next = state_reg | set_ev;
      if (wr_ok && !ADDR[6]) begin
         case (grp)
            `IDC_A_DO: do_next = put16(do_reg, slice, WDATA);
            `IDC_A_EDGE_LO, `IDC_A_EDGE_HI: begin
               if (ADDR[1]) begin
                  fall_next = put16(fall_reg, eslice, WDATA);
               end else begin
                  rise_next = put16(rise_reg, eslice, WDATA);
               end
            end
            // Write one to clear; a new event in the same cycle wins
            `IDC_A_STATE: state_next = (state_reg & ~put16(`IDC_RST_64, slice, WDATA)) | set_ev;
            `IDC_A_FEN: fen_next = put16(fen_reg, slice, WDATA);
            default: begin
               case (ADDR)
                  `IDC_A_FPRE_LO: fpre_next[15:0] = WDATA;
                  `IDC_A_FPRE_HI: fpre_next[31:16] = WDATA;
                  `IDC_A_WDV_LO: wdv_next[15:0] = WDATA;
                  `IDC_A_WDV_HI: wdv_next[31:16] = WDATA;
                  `IDC_A_WDCTL: wden_next = WDATA[`IDC_WDCTL_EN];
                  `IDC_A_EECTL: begin
                     if (WDATA[`IDC_EE_STORE]) begin
                        store_next = do_reg;
                        ee_done_next = 1'b1;
                     end
                  end
                  default: ee_done_next = ee_done_reg;
               endcase
            end
         endcase
      end
      // Safe image latched once, so later writes are the only change
      if (expired && !exp_d_reg) begin
         do_next = store_reg;
      end
      if (hot_ev && !jumper_pin) begin
         do_next = store_reg;
      end
      if (boot_reg) begin
         do_next = store_reg;
      end
   end

   // Read mux, unmapped offsets read zero
   always @* begin
      rdata_next = `IDC_RST_16;
      if (!ADDR[6]) begin
         case (grp)
            `IDC_A_DI: rdata_next = get16(filt, slice);
            `IDC_A_DO: rdata_next = get16(do_reg, slice);
            `IDC_A_EDGE_LO, `IDC_A_EDGE_HI: begin
               rdata_next = ADDR[1] ? get16(fall_reg, eslice) : get16(rise_reg, eslice);
            end
            `IDC_A_STATE: rdata_next = get16(state_reg, slice);
            `IDC_A_FEN: rdata_next = get16(fen_reg, slice);
            default: begin
               case (ADDR)
                  `IDC_A_FPRE_LO: rdata_next = fpre_reg[15:0];
                  `IDC_A_FPRE_HI: rdata_next = fpre_reg[31:16];
                  `IDC_A_WDV_LO: rdata_next = wdv_reg[15:0];
                  `IDC_A_WDV_HI: rdata_next = wdv_reg[31:16];
                  `IDC_A_WDCTL: rdata_next = {14'h0000, wden_reg, expired};
                  `IDC_A_EECTL: rdata_next = {15'h0000, ee_done_reg};
                  `IDC_A_CARD: rdata_next = {12'h000, card_number};
                  default: rdata_next = `IDC_RST_16;
               endcase
            end
         endcase
      end else if (ADDR == `IDC_A_PORTID) begin
         rdata_next = {8'h00, port_id};
      end
   end

   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         do_reg <= `IDC_RST_64;
         rise_reg <= `IDC_RST_64;
         fall_reg <= `IDC_RST_64;
         state_reg <= `IDC_RST_64;
         fen_reg <= `IDC_RST_64;
         store_reg <= `IDC_RST_64;
         fpre_reg <= `IDC_RST_32;
         wdv_reg <= `IDC_RST_32;
         wden_reg <= 1'b0;
         wdclr_reg <= 1'b0;
         ee_done_reg <= 1'b0;
         boot_reg <= 1'b1;
         exp_d_reg <= 1'b0;
         filt_d_reg <= `IDC_RST_64;
         RDATA <= `IDC_RST_16;
      end else begin
         do_reg <= do_next;
         rise_reg <= rise_next;
         fall_reg <= fall_next;
         state_reg <= state_next;
         fen_reg <= fen_next;
         store_reg <= store_next;
         fpre_reg <= fpre_next;
         wdv_reg <= wdv_next;
         wden_reg <= wden_next;
         wdclr_reg <= wr_ok && ADDR == `IDC_A_WDCLR;
         ee_done_reg <= ee_done_next;
         boot_reg <= 1'b0;
         exp_d_reg <= expired;
         filt_d_reg <= filt;
         if (RD) begin
            RDATA <= rdata_next;
         end
      end
   end

endmodule // idc_top

// *** sim/idc_top_chk.sv ***
`timescale 1ns/1ps
module idc_top_chk (
   // Clock and reset
   input logic CLOCK,
   input logic RST_B,
   // Host port
   input logic [6:0] ADDR,
   input logic WR,
   input logic RD,
   input logic [15:0] WDATA,
   input logic [15:0] RDATA,
   input logic IRQ,
   // Field pins
   input logic [63:0] DI,
   input logic [63:0] DO,
   input logic SAMPLE_CLK,
   input logic HOT_RESET_B,
   input logic HOT_RESET_OUTPUT_JUMPER,
   input logic [3:0] CARD_NUMBER_DIP_SWITCH
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   logic wd_en_reg;
   logic edge_cfg_reg;
   logic [31:0] fpre_reg;
   logic [3:0] sw_cnt_reg;
   logic [3:0] sw_d_reg;
   // Filter preset shadow skips writes while the timer is armed, as those may be refused
   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         wd_en_reg <= 1'b0;
         edge_cfg_reg <= 1'b0;
         fpre_reg <= 32'h00000000;
         sw_cnt_reg <= 4'h0;
         sw_d_reg <= 4'h0;
      end else begin
         sw_d_reg <= CARD_NUMBER_DIP_SWITCH;
         if (WR && ADDR == 7'h38) wd_en_reg <= WDATA[0];
         if (WR && ADDR[6:4] == 3'b001 && WDATA != 16'h0000) edge_cfg_reg <= 1'b1;
         if (WR && !wd_en_reg && ADDR == 7'h30) fpre_reg[15:0] <= WDATA;
         if (WR && !wd_en_reg && ADDR == 7'h32) fpre_reg[31:16] <= WDATA;
         // Switch must settle through the synchroniser first
         if (CARD_NUMBER_DIP_SWITCH != sw_d_reg) sw_cnt_reg <= 4'h0;
         else if (sw_cnt_reg != 4'hf) sw_cnt_reg <= sw_cnt_reg + 4'h1;
      end
   end
   property p_card;
      RD && ADDR == 7'h3e && sw_cnt_reg == 4'hf |=> RDATA == {12'h000, CARD_NUMBER_DIP_SWITCH};
   endproperty
   a_card: assert property (p_card) else $error("card number read wrong");
   property p_do_zero;
      $rose(RST_B) |-> DO == 64'h0;
   endproperty
   a_do_zero: assert property (p_do_zero) else $error("outputs not off after reset");
   property p_do_write;
      WR && ADDR == 7'h08 && !wd_en_reg |=> DO[15:0] == $past(WDATA);
   endproperty
   a_do_write: assert property (p_do_write) else $error("output write lost");
   property p_irq_hold;
      IRQ && !(WR && ADDR[6:3] == 4'h4) |=> IRQ;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("request dropped uncleared");
   property p_irq_cfg;
      !edge_cfg_reg |-> !IRQ;
   endproperty
   a_irq_cfg: assert property (p_irq_cfg) else $error("request with no edge enabled");
   property p_keep;
      HOT_RESET_OUTPUT_JUMPER && !wd_en_reg && !WR |=> $stable(DO);
   endproperty
   a_keep: assert property (p_keep) else $error("outputs moved without a write");
   property p_portid;
      RD && ADDR == 7'h40 && IRQ |=> RDATA != 16'h0000 && RDATA[15:8] == 8'h00;
   endproperty
   a_portid: assert property (p_portid) else $error("port identify disagrees");
   property p_fpre;
      RD && ADDR[6:2] == 5'b01100 && !wd_en_reg |=> RDATA == ($past(ADDR[1]) ? fpre_reg[31:16] : fpre_reg[15:0]);
   endproperty
   a_fpre: assert property (p_fpre) else $error("filter preset readback wrong");
   c_irq_up: cover property ($rose(IRQ));
   c_irq_down: cover property ($fell(IRQ));
   c_card: cover property (RD && ADDR == 7'h3e);
endmodule // idc_top_chk

bind idc_top idc_top_chk u_chk (.CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WR(WR), .RD(RD),
   .WDATA(WDATA), .RDATA(RDATA), .IRQ(IRQ), .DI(DI), .DO(DO), .SAMPLE_CLK(SAMPLE_CLK),
   .HOT_RESET_B(HOT_RESET_B), .HOT_RESET_OUTPUT_JUMPER(HOT_RESET_OUTPUT_JUMPER),
   .CARD_NUMBER_DIP_SWITCH(CARD_NUMBER_DIP_SWITCH));

// *** sim/idc_host.sv ***
`timescale 1ns/1ps
module idc_host (
   // Clock
   input logic CLOCK,
   // Register port
   output logic [6:0] ADDR,
   output logic WR,
   output logic RD,
   output logic [15:0] WDATA,
   input logic [15:0] RDATA
);
   initial begin
      ADDR = 7'h00;
      WR = 1'b0;
      RD = 1'b0;
      WDATA = 16'h0000;
   end
   // Whole words only, one strobe cycle each
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(negedge CLOCK);
      ADDR = a;
      WDATA = d;
      WR = 1'b1;
      @(negedge CLOCK);
      WR = 1'b0;
      WDATA = ~d;
   endtask
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      @(negedge CLOCK);
      ADDR = a;
      RD = 1'b1;
      @(negedge CLOCK);
      RD = 1'b0;
      d = RDATA;
   endtask
endmodule // idc_host

// *** sim/tb_isolated_dio_control_logic.sv ***
`timescale 1ns/1ps
module tb_isolated_dio_control_logic;
   logic clock, rst_b, sample_clk, hot_b, jumper, irq, wr, rd, e;
   logic [6:0] addr;
   logic [15:0] wdata, rdata, r, v;
   logic [3:0] sw;
   logic [63:0] di, do_pins;
   int mismatches, total_checks, i, k;

   idc_top uut (.CLOCK(clock), .RST_B(rst_b), .ADDR(addr), .WR(wr), .RD(rd), .WDATA(wdata), .RDATA(rdata),
      .IRQ(irq), .DI(di), .DO(do_pins), .SAMPLE_CLK(sample_clk), .HOT_RESET_B(hot_b),
      .HOT_RESET_OUTPUT_JUMPER(jumper), .CARD_NUMBER_DIP_SWITCH(sw));
   idc_host host (.CLOCK(clock), .ADDR(addr), .WR(wr), .RD(rd), .WDATA(wdata), .RDATA(rdata));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Phase unrelated to the bus clock
   initial begin
      sample_clk = 1'b0;
      #37;
      forever #200 sample_clk = ~sample_clk;
   end

   function automatic logic [15:0] bit_of(input int n);
      return 16'h0001 << n;
   endfunction
   task chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wait_n(input int n);
      repeat (n) @(negedge clock);
   endtask
   task hot(input logic j);
      jumper = j;
      wait_n(4);
      hot_b = 1'b0;
      wait_n(4);
      hot_b = 1'b1;
      wait_n(10);
   endtask
   task pulse(input int ns, input logic exp);
      di[0] = 1'b1;
      #(ns);
      di[0] = 1'b0;
      wait_n(200);
      chk(irq, exp);
      host.wr(7'h20, 16'h0001);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      #2000000;
      mismatches++;
      end_of_test;
   end

   initial begin
      rst_b = 1'b0;
      hot_b = 1'b1;
      jumper = 1'b1;
      void'($urandom(19));
      sw = 4'($urandom);
      di = {$urandom, $urandom};
      repeat (16) @(posedge clock);
      @(negedge clock) rst_b = 1'b1;
      wait_n(8);
      for (i = 0; i < 4; i++) begin
         host.rd(7'h08 + 7'(2 * i), r);
         chk(r, 16'h0000);
      end
      host.rd(7'h3e, r);
      chk(r, {12'h000, sw});
      host.rd(7'h42, r);
      chk(r, 16'h0000);
      host.rd(7'h00, r);
      chk(r, di[15:0]);
      $display("test reset done");
      for (i = 0; i < 4; i++) begin
         v = 16'($urandom);
         host.wr(7'h08 + 7'(2 * i), v);
         chk(do_pins[16 * i +: 16], v);
      end
      v = do_pins[15:0];
      hot(1'b1);
      chk(do_pins[15:0], v);
      hot(1'b0);
      chk(do_pins, 64'h0);
      $display("test outputs done");
      k = $urandom_range(15);
      di[k] = 1'b0;
      wait_n(10);
      for (i = 0; i < 4; i++) begin
         if (i % 2 == 0) begin
            host.wr(7'h10, (i == 0) ? bit_of(k) : 16'h0000);
            host.wr(7'h12, (i == 2) ? bit_of(k) : 16'h0000);
         end
         di[k] = ~di[k];
         wait_n(10);
         e = (i < 2) ? di[k] : ~di[k];
         chk(irq, e);
         host.rd(7'h40, r);
         chk(r, e ? bit_of(k / 8) : 16'h0000);
         host.rd(7'h20, r);
         chk(r, e ? bit_of(k) : 16'h0000);
         host.wr(7'h20, bit_of(k));
         wait_n(2);
         chk(irq, 1'b0);
      end
      $display("test interrupt done");
      for (i = 0; i < 2; i++) begin
         v = 16'($urandom);
         host.wr(7'h30 + 7'(2 * i), v);
         host.rd(7'h30 + 7'(2 * i), r);
         chk(r, v);
      end
      di[0] = 1'b0;
      host.wr(7'h30, 16'h0008);
      host.wr(7'h32, 16'h0000);
      host.wr(7'h28, 16'h0001);
      host.wr(7'h10, 16'h0001);
      host.wr(7'h12, 16'h0000);
      wait_n(200);
      host.wr(7'h20, 16'hffff);
      pulse(1200, 1'b0);
      pulse(4000, 1'b1);
      $display("test filter done");
      host.wr(7'h08, 16'h00a5);
      host.wr(7'h3c, 16'h8000);
      host.rd(7'h3c, r);
      chk(r[0], 1'b1);
      host.wr(7'h08, 16'hffff);
      host.wr(7'h34, 16'h0005);
      host.wr(7'h36, 16'h0000);
      host.wr(7'h38, 16'h0001);
      repeat (4) host.wr(7'h3a, 16'h0000);
      chk(do_pins[15:0], 16'hffff);
      wait_n(40);
      chk(do_pins[15:0], 16'h00a5);
      host.wr(7'h08, 16'h1234);
      chk(do_pins[15:0], 16'h00a5);
      host.rd(7'h38, r);
      chk(r[1:0], 2'b11);
      host.wr(7'h38, 16'h0000);
      host.wr(7'h08, 16'h1234);
      chk(do_pins[15:0], 16'h1234);
      hot(1'b0);
      chk(do_pins[15:0], 16'h00a5);
      $display("test watchdog done");
      end_of_test;
   end
endmodule // tb_isolated_dio_control_logic
